// ### dac_model.sv
`timescale 1ns/1ps
module dac_model (
    // Bus pins
    input wire [7:0]   d_i,
    input wire         s0_i,
    input wire         s1_i,
    input wire         cs_n_i,
    input wire         wr_n_i,
    input wire         ld_n_i,
    // Converter codes
    output reg [11:0]  out_a_o,
    output reg [11:0]  out_b_o
);
reg [7:0] lat [0:3];
// Latch on the closing edge, as the real part does
always @(posedge wr_n_i) begin
    if (!cs_n_i)
        lat[{s1_i, s0_i}] <= d_i;
end
always @(negedge ld_n_i) begin
    out_a_o <= {lat[1][3:0], lat[0]};
    out_b_o <= {lat[3][3:0], lat[2]};
end
endmodule

// ### dac_port_map.vh
// How it works
// - Low byte: code bits 7..0 on bus lines 7..0, line 0 is LSB.
// - High byte: code bits 11..8 on bus lines 3..0, line 3 is MSB.
// - Two select lines pick one of four input latches; first is LSB.
// - Write strobe low pulse with chip select low stores bus data.
`ifndef DAC_PORT_MAP_VH
`define DAC_PORT_MAP_VH

// ----------------------------------------
// Latch select codes
// ----------------------------------------
`define SEL_A_LOW        2'h0
`define SEL_A_HIGH       2'h1
`define SEL_B_LOW        2'h2
`define SEL_B_HIGH       2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS    25
`define SETUP_NS         80
`define STROBE_NS        100
`define HOLD_NS          10
`define SETUP_CYC   ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC  ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC    ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W            3

`endif

// ### dac_port_props.sv
`timescale 1ns/1ps
module dac_port_props (
    // Clock and reset
    input wire       clock_i,
    input wire       rst_i,
    // Device pins
    input wire [7:0] bus_data_o,
    input wire       latch_sel_lo_o,
    input wire       chip_sel_n_o,
    input wire       write_n_o,
    input wire       load_outputs_n_o
);
default clocking @(posedge clock_i); endclocking
default disable iff (rst_i);
sequence s_strobe;
    (!write_n_o && !chip_sel_n_o && $stable(bus_data_o))[*5]
        ##1 (write_n_o && $stable(bus_data_o));
endsequence
property p_strobe; $fell(write_n_o) |-> s_strobe; endproperty
property p_setup;
    $fell(write_n_o) |-> $past(bus_data_o, 3) == bus_data_o
        && $past(latch_sel_lo_o, 3) == latch_sel_lo_o;
endproperty
property p_high;
    $fell(write_n_o) && latch_sel_lo_o |-> bus_data_o[7:4] == 4'h0;
endproperty
property p_pair;
    $fell(write_n_o) && !latch_sel_lo_o
        |-> ##[5:14] ($fell(write_n_o) && latch_sel_lo_o);
endproperty
property p_load;
    $fell(load_outputs_n_o) |-> (!load_outputs_n_o && write_n_o)[*5]
        ##1 load_outputs_n_o;
endproperty
a_strobe: assert property (p_strobe) else $error("write strobe bad");
a_setup: assert property (p_setup) else $error("bus setup bad");
a_high: assert property (p_high) else $error("high byte bad");
a_pair: assert property (p_pair) else $error("byte pair bad");
a_load: assert property (p_load) else $error("load strobe bad");
endmodule
bind dual_dac_byte_load_port dac_port_props u_props (
    .clock_i(clock_i), .rst_i(rst_i), .bus_data_o(bus_data_o),
    .latch_sel_lo_o(latch_sel_lo_o), .chip_sel_n_o(chip_sel_n_o),
    .write_n_o(write_n_o), .load_outputs_n_o(load_outputs_n_o));

// ### dual_dac_byte_load_port.v
`timescale 1ns/1ps
`include "dac_port_map.vh"

module dual_dac_byte_load_port (
    // Clock and reset
    input  wire        clock_i,
    input  wire        rst_i,
    // User request
    input  wire        req_valid_i,
    input  wire        req_chan_i,
    input  wire [11:0] req_code_i,
    input  wire        req_load_i,
    output wire        req_ready_o,
    output wire        busy_o,
    // Device pins
    output wire [7:0]  bus_data_o,
    output wire        latch_sel_lo_o,
    output wire        latch_sel_hi_o,
    output wire        chip_sel_n_o,
    output wire        write_n_o,
    output wire        load_outputs_n_o
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [5:0] S_IDLE  = 6'h01;
    localparam [5:0] S_SETUP = 6'h02;
    localparam [5:0] S_STRB  = 6'h04;
    localparam [5:0] S_HOLD  = 6'h08;
    localparam [5:0] S_LOAD  = 6'h10;
    localparam [5:0] S_GAP   = 6'h20;

    localparam [31:0]       SETUP_W  = `SETUP_CYC;
    localparam [31:0]       STROBE_W = `STROBE_CYC;
    localparam [31:0]       HOLD_W   = `HOLD_CYC;
    localparam [`CNT_W-1:0] SETUP_C  = SETUP_W[`CNT_W-1:0];
    localparam [`CNT_W-1:0] STROBE_C = STROBE_W[`CNT_W-1:0];
    localparam [`CNT_W-1:0] HOLD_C   = HOLD_W[`CNT_W-1:0];

    reg [5:0]        state_r;
    reg [5:0]        state_nxt;
    reg [11:0]       code_r;
    reg              chan_r;
    reg              high_r;
    reg              load_r;
    reg [7:0]        data_r;
    reg [1:0]        sel_r;
    reg              cs_n_r;
    reg              wr_n_r;
    reg              ld_n_r;
    reg              tload;
    reg [`CNT_W-1:0] tcount;
    wire             tdone;

    phase_timer timer_u (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .load_i  (tload),
        .count_i (tcount),
        .done_o  (tdone)
    );

    assign req_ready_o = (state_r == S_IDLE);
    assign busy_o      = (state_r != S_IDLE);

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always @* begin
        state_nxt = state_r;
        tload     = 1'b0;
        tcount    = SETUP_C;
        case (state_r)
            S_IDLE: begin
                if (req_valid_i) begin
                    tload     = 1'b1;
                    tcount    = req_load_i ? STROBE_C : SETUP_C;
                    state_nxt = req_load_i ? S_LOAD : S_SETUP;
                end
            end
            S_SETUP: begin
                if (tdone) begin
                    tload     = 1'b1;
                    tcount    = STROBE_C;
                    state_nxt = S_STRB;
                end
            end
            S_STRB: begin
                if (tdone) begin
                    tload     = 1'b1;
                    tcount    = HOLD_C;
                    state_nxt = S_HOLD;
                end
            end
            S_HOLD: begin
                if (tdone) begin
                    if (!high_r) begin
                        // Second byte of the same code follows at once
                        tload     = 1'b1;
                        tcount    = SETUP_C;
                        state_nxt = S_SETUP;
                    end else if (load_r) begin
                        tload     = 1'b1;
                        tcount    = STROBE_C;
                        state_nxt = S_LOAD;
                    end else begin
                        state_nxt = S_IDLE;
                    end
                end
            end
            S_LOAD: begin
                if (tdone) begin
                    tload     = 1'b1;
                    tcount    = HOLD_C;
                    state_nxt = S_GAP;
                end
            end
            S_GAP: begin
                if (tdone) begin
                    state_nxt = S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Pin registers
    // ----------------------------------------
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
            code_r  <= 12'h000;
            chan_r  <= 1'b0;
            high_r  <= 1'b0;
            load_r  <= 1'b0;
            data_r  <= 8'h00;
            sel_r   <= `SEL_A_LOW;
            cs_n_r  <= 1'b1;
            wr_n_r  <= 1'b1;
            ld_n_r  <= 1'b1;
        end else begin
            state_r <= state_nxt;
            if (state_r == S_IDLE && req_valid_i) begin
                code_r <= req_code_i;
                chan_r <= req_chan_i;
                load_r <= req_load_i;
                high_r <= 1'b0;
                if (!req_load_i) begin
                    data_r <= req_code_i[7:0];
                    sel_r  <= req_chan_i ? `SEL_B_LOW : `SEL_A_LOW;
                    cs_n_r <= 1'b0;
                end else begin
                    ld_n_r <= 1'b0;
                end
            end
            if (state_r == S_SETUP && tdone) begin
                wr_n_r <= 1'b0;
            end
            if (state_r == S_STRB && tdone) begin
                wr_n_r <= 1'b1;
            end
            if (state_r == S_HOLD && tdone) begin
                if (!high_r) begin
                    high_r <= 1'b1;
                    data_r <= {4'h0, code_r[11:8]};
                    sel_r  <= chan_r ? `SEL_B_HIGH : `SEL_A_HIGH;
                end else begin
                    // Release select only after the hold has passed
                    cs_n_r <= 1'b1;
                    if (load_r) begin
                        ld_n_r <= 1'b0;
                    end
                end
            end
            if (state_r == S_LOAD && tdone) begin
                ld_n_r <= 1'b1;
            end
        end
    end

    assign bus_data_o       = data_r;
    assign latch_sel_lo_o   = sel_r[0];
    assign latch_sel_hi_o   = sel_r[1];
    assign chip_sel_n_o     = cs_n_r;
    assign write_n_o        = wr_n_r;
    assign load_outputs_n_o = ld_n_r;

endmodule

// ### dual_dac_byte_load_port_tb.sv
`timescale 1ns/1ps
module dual_dac_byte_load_port_tb;
reg         clock_i = 0, rst_i = 1, req_valid_i = 0;
reg         req_chan_i = 0, req_load_i = 0;
reg  [11:0] req_code_i = 12'h000;
wire        req_ready_o, busy_o, sel_lo, sel_hi, cs_n, wr_n, ld_n;
wire [7:0]  bus_data;
wire [11:0] out_a, out_b;
integer     num_errors = 0, samples_checked = 0;
always #12.5 clock_i = ~clock_i;
dual_dac_byte_load_port DUT (.clock_i(clock_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_chan_i(req_chan_i),
    .req_code_i(req_code_i), .req_load_i(req_load_i),
    .req_ready_o(req_ready_o), .busy_o(busy_o), .bus_data_o(bus_data),
    .latch_sel_lo_o(sel_lo), .latch_sel_hi_o(sel_hi), .chip_sel_n_o(cs_n),
    .write_n_o(wr_n), .load_outputs_n_o(ld_n));
dac_model far (.d_i(bus_data), .s0_i(sel_lo), .s1_i(sel_hi),
    .cs_n_i(cs_n), .wr_n_i(wr_n), .ld_n_i(ld_n),
    .out_a_o(out_a), .out_b_o(out_b));
task results; begin
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
end endtask
task check(input [95:0] nm, input [11:0] seen, input [11:0] exp); begin
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
    end
end endtask
task wait_ready; integer n; begin
    n = 0;
    while (req_ready_o !== 1'b1) begin
        @(negedge clock_i);
        n = n + 1;
        if (n > 100) begin
            num_errors = num_errors + 1;
            results;
        end
    end
end endtask
task send(input ch, input [11:0] code, input ld); begin
    wait_ready;
    req_valid_i = 1;
    req_chan_i = ch;
    req_code_i = code;
    req_load_i = ld;
    @(negedge clock_i);
    req_valid_i = 0;
end endtask
// Outputs must hold the old pair until the load strobe
task t_codes; integer i; reg [11:0] c, prev; begin
    for (i = 0; i < 3; i = i + 1) begin
        c = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'h5A3;
        send(0, c, 0);
        send(1, ~c, 0);
        wait_ready;
        if (i > 0) check("hold_a", out_a, prev);
        if (i > 0) check("hold_b", out_b, ~prev);
        send(0, 12'h000, 1);
        wait_ready;
        check("code_a", out_a, c);
        check("code_b", out_b, ~c);
        prev = c;
    end
end endtask
// A request held while busy must not reach the bus
task t_refused; integer i; begin
    send(1, 12'h321, 0);
    check("busy", {busy_o, req_ready_o}, 12'h002);
    req_valid_i = 1;
    req_chan_i = 0;
    req_code_i = 12'hCDE;
    for (i = 0; i < 4; i = i + 1) @(negedge clock_i);
    req_valid_i = 0;
    send(0, 12'h000, 1);
    wait_ready;
    check("refused_b", out_b, 12'h321);
    check("refused_a", out_a, 12'h5A3);
end endtask
initial begin
    repeat (10) @(negedge clock_i);
    rst_i = 0;
    check("idle", {cs_n, wr_n, ld_n}, 12'h007);
    t_codes;
    t_refused;
    results;
end
endmodule

// ### phase_timer.v
`timescale 1ns/1ps
`include "dac_port_map.vh"

module phase_timer (
    // Clock and reset
    input  wire             clock_i,
    input  wire             rst_i,
    // Control
    input  wire             load_i,
    input  wire [`CNT_W-1:0] count_i,
    output wire             done_o
);

    reg [`CNT_W-1:0] cnt_r;

    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= 3'h0;
        end else if (load_i) begin
            cnt_r <= count_i;
        end else if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
        end
    end

    // Count only: gating with load_i would loop through the sequencer
    assign done_o = (cnt_r == 3'h0);

endmodule
